// ### hdl/car_pkg.sv
// Constants and types shared by the configuration access router.
package car_pkg;

	localparam logic [15:0] CAR_SELECT_IO   = 16'h0CF8;
	localparam logic [15:0] CAR_WINDOW_IO   = 16'h0CFC;
	localparam logic [31:0] CAR_SELECT_MASK = 32'h80FF_FFFC;
	localparam logic [31:0] CAR_SELECT_RST  = 32'h0000_0000;
	localparam logic [31:0] CAR_ABORT_DATA  = 32'hFFFF_FFFF;
	localparam logic [3:0]  CAR_BE_ALL      = 4'hF;

	localparam int CAR_EN_BIT  = 31;
	localparam int CAR_BUS_HI  = 23;
	localparam int CAR_BUS_LO  = 16;
	localparam int CAR_DEV_HI  = 15;
	localparam int CAR_DEV_LO  = 11;
	localparam int CAR_FUNC_HI = 10;
	localparam int CAR_FUNC_LO = 8;
	localparam int CAR_REG_HI  = 7;
	localparam int CAR_REG_LO  = 2;

	localparam int CAR_MM_BUS_HI  = 27;
	localparam int CAR_MM_BUS_LO  = 20;
	localparam int CAR_MM_DEV_HI  = 19;
	localparam int CAR_MM_DEV_LO  = 15;
	localparam int CAR_MM_FUNC_HI = 14;
	localparam int CAR_MM_FUNC_LO = 12;
	localparam int CAR_MM_REG_HI  = 7;
	localparam int CAR_MM_REG_LO  = 2;

	localparam logic [7:0] CAR_FIXED_BUS  = 8'h00;
	localparam logic [4:0] CAR_FIXED_DEV  = 5'h10;
	localparam logic [2:0] CAR_FIXED_FUNC = 3'h0;
	localparam int         CAR_FIXED_HI   = 15;
	localparam int         CAR_FIXED_LO   = 10;

	localparam logic [1:0] CAR_LINK_TYPE0 = 2'h0;
	localparam logic [1:0] CAR_LINK_TYPE1 = 2'h1;
	localparam logic [6:0] CAR_RSVD_ZERO  = 7'h00;

	typedef enum logic [1:0] {
		CAR_KIND_IO,
		CAR_KIND_MEM_CFG,
		CAR_KIND_FIXED,
		CAR_KIND_LINK_MEM_CFG
	} car_kind_e;

	typedef enum logic [1:0] {
		CAR_IDLE,
		CAR_INT_WAIT,
		CAR_LINK_WAIT
	} car_fsm_e;

	typedef struct packed {
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] func;
		logic [5:0] regi;
	} car_target_s;

	typedef struct packed {
		car_fsm_e    fsm;
		logic [31:0] select;
		car_target_s tgt;
		logic        write;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic        relay;
		logic        busy;
		logic        done;
		logic        abort;
		logic        pass;
		logic [31:0] rdata;
		logic        int_valid;
		logic        sl_valid;
		logic [31:0] sl_addr;
	} car_state_s;

endpackage

// ### hdl/car_router.sv
// Configuration access router: decodes host accesses and routes them.
// What this block does
// - Bus 0 requests are claimed internally, relayed as Type 0 or aborted, never sent on as Type 1.
// - Internal register targets never see Type 1 requests.
// - Missing targets abort: writes dropped, reads return all ones.
// - Eight bus bits, 32 devices, 8 functions, 64 dwords of registers.
// - Select register at I/O 0xCF8, data window at I/O 0xCFC to 0xCFF.
// - No data window configuration cycle unless select bit 31 is set.
// - Each data window access becomes a cycle to the selected dword.
// - Bus field in bits 23:16; zero bus routes to bus 0 devices.
// - Bridge function at bus 0 relays south bridge requests over the link.
// - Non-zero bus goes out Type 1: address bits 1:0 are 01, 31:2 copied.
// - All hub registers sit on bus 0 and take Type 0 accesses.
// - Memory-mapped config arriving from the south link is aborted.
// - Fixed host bus window maps to bus 0, device 16, function 0, four bytes.
// - Select register changes only on dword access; others pass as plain I/O.
module car_router (
	input  wire logic              i_core_clk,
	input  wire logic              i_reset_n,
	input  wire logic              i_req_valid,
	input  wire car_pkg::car_kind_e i_req_kind,
	input  wire logic              i_req_write,
	input  wire logic [31:0]       i_req_addr,
	input  wire logic [3:0]        i_req_be,
	input  wire logic [31:0]       i_req_wdata,
	output logic                   o_busy,
	output logic                   o_done,
	output logic                   o_abort,
	output logic                   o_pass,
	output logic [31:0]            o_rdata,
	output logic                   o_int_valid,
	output logic                   o_int_write,
	output logic [4:0]             o_int_dev,
	output logic [2:0]             o_int_func,
	output logic [5:0]             o_int_reg,
	output logic [3:0]             o_int_be,
	output logic [31:0]            o_int_wdata,
	input  wire logic              i_int_done,
	input  wire logic              i_int_hit,
	input  wire logic [31:0]       i_int_rdata,
	output logic                   o_sl_valid,
	output logic                   o_sl_write,
	output logic [31:0]            o_sl_addr,
	output logic [3:0]             o_sl_be,
	output logic [31:0]            o_sl_wdata,
	input  wire logic              i_sl_done,
	input  wire logic              i_sl_ok,
	input  wire logic [31:0]       i_sl_rdata
);

	logic                rst_meta_reg;
	logic                rst_n_reg;
	car_pkg::car_state_s st_reg;
	car_pkg::car_state_s st_next;
	car_pkg::car_target_s req_tgt;
	logic                accept;

	function automatic car_pkg::car_target_s f_from_select(
		input logic [31:0] sel
	);
		car_pkg::car_target_s t;
		t.bus  = sel[car_pkg::CAR_BUS_HI:car_pkg::CAR_BUS_LO];
		t.dev  = sel[car_pkg::CAR_DEV_HI:car_pkg::CAR_DEV_LO];
		t.func = sel[car_pkg::CAR_FUNC_HI:car_pkg::CAR_FUNC_LO];
		t.regi = sel[car_pkg::CAR_REG_HI:car_pkg::CAR_REG_LO];
		return t;
	endfunction

	// Builds the south link address; the select register layout is kept.
	function automatic logic [31:0] f_link_addr(
		input car_pkg::car_target_s t,
		input logic [1:0]           typ
	);
		return {1'b1, car_pkg::CAR_RSVD_ZERO, t.bus, t.dev, t.func,
			t.regi, typ};
	endfunction

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	assign accept = i_req_valid && (st_reg.fsm == car_pkg::CAR_IDLE);

	always_comb begin
		req_tgt = f_from_select(st_reg.select);
		unique case (i_req_kind)
			car_pkg::CAR_KIND_MEM_CFG: begin
				req_tgt.bus  = i_req_addr[car_pkg::CAR_MM_BUS_HI:
					car_pkg::CAR_MM_BUS_LO];
				req_tgt.dev  = i_req_addr[car_pkg::CAR_MM_DEV_HI:
					car_pkg::CAR_MM_DEV_LO];
				req_tgt.func = i_req_addr[car_pkg::CAR_MM_FUNC_HI:
					car_pkg::CAR_MM_FUNC_LO];
				req_tgt.regi = i_req_addr[car_pkg::CAR_MM_REG_HI:
					car_pkg::CAR_MM_REG_LO];
			end
			car_pkg::CAR_KIND_FIXED: begin
				req_tgt.bus  = car_pkg::CAR_FIXED_BUS;
				req_tgt.dev  = car_pkg::CAR_FIXED_DEV;
				req_tgt.func = car_pkg::CAR_FIXED_FUNC;
				req_tgt.regi = i_req_addr[car_pkg::CAR_FIXED_HI:
					car_pkg::CAR_FIXED_LO];
			end
			default: begin
			end
		endcase
	end

	always_comb begin
		st_next           = st_reg;
		st_next.done      = 1'b0;
		st_next.abort     = 1'b0;
		st_next.pass      = 1'b0;
		st_next.int_valid = 1'b0;
		st_next.sl_valid  = 1'b0;
		unique case (st_reg.fsm)
			car_pkg::CAR_IDLE: begin
				if (accept) begin
					st_next.write = i_req_write;
					st_next.wdata = i_req_wdata;
					st_next.be    = i_req_be;
					st_next.tgt   = req_tgt;
					st_next.relay = (i_req_kind != car_pkg::CAR_KIND_FIXED);
					st_next.done  = 1'b1;
					st_next.rdata = 32'h0000_0000;
					unique case (i_req_kind)
						car_pkg::CAR_KIND_IO: begin
							if (i_req_addr[15:0] == car_pkg::CAR_SELECT_IO &&
								i_req_be == car_pkg::CAR_BE_ALL) begin
								if (i_req_write) begin
									st_next.select = i_req_wdata &
										car_pkg::CAR_SELECT_MASK;
								end else begin
									st_next.rdata = st_reg.select;
								end
							end else if (i_req_addr[15:2] ==
								car_pkg::CAR_WINDOW_IO[15:2] &&
								st_reg.select[car_pkg::CAR_EN_BIT]) begin
								st_next.done = 1'b0;
							end else begin
								st_next.pass = 1'b1;
							end
						end
						car_pkg::CAR_KIND_LINK_MEM_CFG: begin
							st_next.abort = 1'b1;
							st_next.rdata = car_pkg::CAR_ABORT_DATA;
						end
						car_pkg::CAR_KIND_FIXED: begin
							st_next.be   = car_pkg::CAR_BE_ALL;
							st_next.done = 1'b0;
						end
						default: begin
							st_next.done = 1'b0;
						end
					endcase
					if (!st_next.done) begin
						st_next.busy = 1'b1;
						if (req_tgt.bus == 8'h00) begin
							st_next.int_valid = 1'b1;
							st_next.fsm       = car_pkg::CAR_INT_WAIT;
						end else begin
							st_next.sl_valid = 1'b1;
							st_next.sl_addr  = f_link_addr(req_tgt,
								car_pkg::CAR_LINK_TYPE1);
							st_next.fsm      = car_pkg::CAR_LINK_WAIT;
						end
					end
				end
			end
			car_pkg::CAR_INT_WAIT: begin
				if (i_int_done) begin
					if (i_int_hit) begin
						st_next.done  = 1'b1;
						st_next.busy  = 1'b0;
						st_next.rdata = st_reg.write ? 32'h0000_0000 :
							i_int_rdata;
						st_next.fsm   = car_pkg::CAR_IDLE;
					end else if (st_reg.relay) begin
						st_next.sl_valid = 1'b1;
						st_next.sl_addr  = f_link_addr(st_reg.tgt,
							car_pkg::CAR_LINK_TYPE0);
						st_next.fsm      = car_pkg::CAR_LINK_WAIT;
					end else begin
						st_next.done  = 1'b1;
						st_next.abort = 1'b1;
						st_next.busy  = 1'b0;
						st_next.rdata = car_pkg::CAR_ABORT_DATA;
						st_next.fsm   = car_pkg::CAR_IDLE;
					end
				end
			end
			car_pkg::CAR_LINK_WAIT: begin
				if (i_sl_done) begin
					st_next.done  = 1'b1;
					st_next.busy  = 1'b0;
					st_next.abort = !i_sl_ok;
					st_next.rdata = i_sl_ok ? i_sl_rdata :
						car_pkg::CAR_ABORT_DATA;
					st_next.fsm   = car_pkg::CAR_IDLE;
				end
			end
			default: begin
				st_next.fsm  = car_pkg::CAR_IDLE;
				st_next.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_busy      = st_reg.busy;
	assign o_done      = st_reg.done;
	assign o_abort     = st_reg.abort;
	assign o_pass      = st_reg.pass;
	assign o_rdata     = st_reg.rdata;
	assign o_int_valid = st_reg.int_valid;
	assign o_int_write = st_reg.write;
	assign o_int_dev   = st_reg.tgt.dev;
	assign o_int_func  = st_reg.tgt.func;
	assign o_int_reg   = st_reg.tgt.regi;
	assign o_int_be    = st_reg.be;
	assign o_int_wdata = st_reg.wdata;
	assign o_sl_valid  = st_reg.sl_valid;
	assign o_sl_write  = st_reg.write;
	assign o_sl_addr   = st_reg.sl_addr;
	assign o_sl_be     = st_reg.be;
	assign o_sl_wdata  = st_reg.wdata;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n_reg);

	sequence s_window_taken;
		accept && i_req_kind == car_pkg::CAR_KIND_IO &&
		i_req_addr[15:2] == car_pkg::CAR_WINDOW_IO[15:2] &&
		!(i_req_addr[15:0] == car_pkg::CAR_SELECT_IO);
	endsequence

	sequence s_select_enabled_remote;
		st_reg.select[car_pkg::CAR_EN_BIT] &&
		st_reg.select[car_pkg::CAR_BUS_HI:car_pkg::CAR_BUS_LO] != 8'h00;
	endsequence

	property p_type1_forward;
		(s_window_taken and s_select_enabled_remote) |=>
			o_sl_valid && o_sl_addr[1:0] == car_pkg::CAR_LINK_TYPE1 &&
			o_sl_addr[31:2] == $past(st_reg.select[31:2]) && !o_int_valid;
	endproperty
	a_type1_forward: assert property (p_type1_forward)
		else $error("Type 1 request not formed from the select register");

	property p_disabled_passes;
		s_window_taken and !st_reg.select[car_pkg::CAR_EN_BIT] |=>
			o_done && o_pass && !o_int_valid && !o_sl_valid;
	endproperty
	a_disabled_passes: assert property (p_disabled_passes)
		else $error("Cycle generated while enable bit clear");

	property p_abort_ones;
		o_done && o_abort |-> o_rdata == car_pkg::CAR_ABORT_DATA;
	endproperty
	a_abort_ones: assert property (p_abort_ones)
		else $error("Aborted access did not return all ones");

	property p_partial_select;
		accept && i_req_kind == car_pkg::CAR_KIND_IO &&
		i_req_addr[15:0] == car_pkg::CAR_SELECT_IO &&
		i_req_be != car_pkg::CAR_BE_ALL |=>
			o_pass && $stable(st_reg.select);
	endproperty
	a_partial_select: assert property (p_partial_select)
		else $error("Partial access changed the select register");

	property p_select_write;
		accept && i_req_kind == car_pkg::CAR_KIND_IO && i_req_write &&
		i_req_addr[15:0] == car_pkg::CAR_SELECT_IO &&
		i_req_be == car_pkg::CAR_BE_ALL |=>
			st_reg.select == ($past(i_req_wdata) &
			car_pkg::CAR_SELECT_MASK) && o_done && !o_pass;
	endproperty
	a_select_write: assert property (p_select_write)
		else $error("Dword write did not load the select register");

	property p_link_memcfg_abort;
		accept && i_req_kind == car_pkg::CAR_KIND_LINK_MEM_CFG |=>
			o_done && o_abort && !o_int_valid && !o_sl_valid;
	endproperty
	a_link_memcfg_abort: assert property (p_link_memcfg_abort)
		else $error("Link config request was not aborted");

	property p_fixed_map;
		accept && i_req_kind == car_pkg::CAR_KIND_FIXED |=>
			o_int_valid && o_int_dev == car_pkg::CAR_FIXED_DEV &&
			o_int_func == car_pkg::CAR_FIXED_FUNC &&
			o_int_be == car_pkg::CAR_BE_ALL &&
			o_int_reg == $past(i_req_addr[15:10]);
	endproperty
	a_fixed_map: assert property (p_fixed_map)
		else $error("Fixed window not mapped to device 16 function 0");

	property p_fixed_miss_aborts;
		st_reg.fsm == car_pkg::CAR_INT_WAIT && !st_reg.relay &&
		i_int_done && !i_int_hit |=> o_done && o_abort && !o_sl_valid;
	endproperty
	a_fixed_miss_aborts: assert property (p_fixed_miss_aborts)
		else $error("Unclaimed hub access was not aborted");

	property p_type0_only_internal;
		o_int_valid |-> st_reg.tgt.bus == 8'h00 ##1 !o_sl_valid[*1];
	endproperty
	a_type0_only_internal: assert property (p_type0_only_internal)
		else $error("Internal target saw a non-zero bus request");

	property p_relay_type0;
		st_reg.fsm == car_pkg::CAR_INT_WAIT && st_reg.relay &&
		i_int_done && !i_int_hit |=>
			o_sl_valid && o_sl_addr[1:0] == car_pkg::CAR_LINK_TYPE0;
	endproperty
	a_relay_type0: assert property (p_relay_type0)
		else $error("Unclaimed bus 0 request not relayed as Type 0");

endmodule

// ### bench/car_partner.sv
// Model of the hub's internal register targets and the south bridge link.
module car_partner (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_slow,
	input  wire logic        i_int_valid,
	input  wire logic        i_int_write,
	input  wire logic [4:0]  i_int_dev,
	input  wire logic [5:0]  i_int_reg,
	input  wire logic [3:0]  i_int_be,
	input  wire logic [31:0] i_int_wdata,
	output logic             o_int_done,
	output logic             o_int_hit,
	output logic [31:0]      o_int_rdata,
	input  wire logic        i_sl_valid,
	input  wire logic [31:0] i_sl_addr,
	output logic             o_sl_done,
	output logic             o_sl_ok,
	output logic [31:0]      o_sl_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [0:63];
	int          cnt_i;
	int          cnt_s;
	always @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_int_done <= 1'b0;
			o_sl_done <= 1'b0;
			o_int_hit <= 1'b0;
			o_sl_ok <= 1'b0;
			o_int_rdata <= 32'h0;
			o_sl_rdata <= 32'h0;
			cnt_i <= 0;
			cnt_s <= 0;
			for (int i = 0; i < 64; i++) mem[i] <= 32'h0;
		end else begin
			o_int_done <= 1'b0;
			o_sl_done <= 1'b0;
			// Returned data is only meaningful in the done cycle.
			o_int_rdata <= ~o_int_rdata;
			o_sl_rdata <= ~o_sl_rdata;
			if (i_int_valid) cnt_i <= i_slow ? 4 : 1;
			else if (cnt_i > 1) cnt_i <= cnt_i - 1;
			else if (cnt_i == 1) begin
				cnt_i <= 0;
				o_int_done <= 1'b1;
				// The top dword of device 16 is absent so the fixed window can miss.
				o_int_hit <= (i_int_dev == 5'h0) ||
					(i_int_dev == 5'h10 && i_int_reg != 6'h3F);
				o_int_rdata <= mem[i_int_reg];
				for (int b = 0; b < 4; b++)
					if (i_int_write && i_int_be[b])
						mem[i_int_reg][8*b+:8] <= i_int_wdata[8*b+:8];
			end
			if (i_sl_valid) cnt_s <= i_slow ? 3 : 1;
			else if (cnt_s > 1) cnt_s <= cnt_s - 1;
			else if (cnt_s == 1) begin
				cnt_s <= 0;
				o_sl_done <= 1'b1;
				// Only bus 1 lies behind the far bridge; others drop.
				o_sl_ok <= (i_sl_addr[1:0] == 2'h1) &&
					(i_sl_addr[23:16] == 8'h01);
				o_sl_rdata <= i_sl_addr;
			end
		end
	end
endmodule

// ### bench/car_router_tb_top.sv
// Self-checking bench for the configuration access router.
module car_router_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic               clk, rst_n, valid, wr, slow, busy, done, abort, pass;
	car_pkg::car_kind_e kind;
	logic [31:0]        addr, wdata, rdata, int_rdata, sl_addr, sl_wdata;
	logic [31:0]        sl_rdata, int_wdata, r_data;
	logic [3:0]         be, int_be, sl_be;
	logic               int_valid, int_write, int_done, int_hit, r_abort;
	logic               sl_valid, sl_write, sl_done, sl_ok, saw_int, saw_sl;
	logic [4:0]         int_dev;
	logic [2:0]         int_func;
	logic [5:0]         int_reg;
	int                 n_fail, checks, cycles;
	logic               r_pass;

	car_router dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_req_valid(valid),
		.i_req_kind(kind), .i_req_write(wr), .i_req_addr(addr), .i_req_be(be),
		.i_req_wdata(wdata), .o_busy(busy), .o_done(done), .o_abort(abort),
		.o_pass(pass), .o_rdata(rdata), .o_int_valid(int_valid),
		.o_int_write(int_write), .o_int_dev(int_dev), .o_int_func(int_func),
		.o_int_reg(int_reg), .o_int_be(int_be), .o_int_wdata(int_wdata),
		.i_int_done(int_done), .i_int_hit(int_hit), .i_int_rdata(int_rdata),
		.o_sl_valid(sl_valid), .o_sl_write(sl_write), .o_sl_addr(sl_addr),
		.o_sl_be(sl_be), .o_sl_wdata(sl_wdata), .i_sl_done(sl_done),
		.i_sl_ok(sl_ok), .i_sl_rdata(sl_rdata));

	car_partner part_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_slow(slow),
		.i_int_valid(int_valid), .i_int_write(int_write), .i_int_dev(int_dev),
		.i_int_reg(int_reg), .i_int_be(int_be), .i_int_wdata(int_wdata),
		.o_int_done(int_done), .o_int_hit(int_hit), .o_int_rdata(int_rdata),
		.i_sl_valid(sl_valid), .i_sl_addr(sl_addr), .o_sl_done(sl_done),
		.o_sl_ok(sl_ok), .o_sl_rdata(sl_rdata));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// The run is about a hundred cycles; the ceiling leaves a wide margin.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (int_valid) saw_int <= 1'b1;
		if (sl_valid) saw_sl <= 1'b1;
		if (cycles == 5000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic req(input car_pkg::car_kind_e k, input logic w,
		input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
		int i;
		kind = k;
		wr = w;
		addr = a;
		be = b;
		wdata = d;
		valid = 1'b1;
		saw_int = 1'b0;
		saw_sl = 1'b0;
		@(posedge clk);
		#1 valid = 1'b0;
		if (done !== 1'b1) chk({31'h0, busy}, 32'h1);
		for (i = 0; i < 40 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk({30'h0, busy, done}, 32'h1);
		r_abort = abort;
		r_pass = pass;
		r_data = rdata;
		// One idle edge keeps valid from being lowered and raised at once.
		@(posedge clk);
		#1;
	endtask

	task automatic io(input logic w, input logic [15:0] a, input logic [3:0] b,
		input logic [31:0] d);
		req(car_pkg::CAR_KIND_IO, w, {16'h0, a}, b, d);
	endtask

	task automatic t_select();
		io(1'b1, 16'h0CF8, 4'hF, 32'hFF12_3457);
		io(1'b0, 16'h0CF8, 4'hF, 32'h0);
		chk(r_data, 32'h8012_3454);
		io(1'b1, 16'h0CF8, 4'h1, 32'h0);
		chk({31'h0, r_pass}, 32'h1);
		io(1'b0, 16'h0CF8, 4'hF, 32'h0);
		chk(r_data, 32'h8012_3454);
	endtask

	// A mid-run reset must return the select register to its disabled value.
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({30'h0, busy, done}, 32'h0);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		io(1'b0, 16'h0CF8, 4'hF, 32'h0);
		chk(r_data, 32'h0000_0000);
	endtask

	task automatic t_disabled();
		io(1'b1, 16'h0CF8, 4'hF, 32'h0000_8014);
		io(1'b0, 16'h0CFC, 4'hF, 32'h0);
		chk({31'h0, r_pass}, 32'h1);
		chk({30'h0, saw_int, saw_sl}, 32'h0);
	endtask

	task automatic t_internal();
		slow = 1'b1;
		io(1'b1, 16'h0CF8, 4'hF, 32'h8000_8014);
		io(1'b1, 16'h0CFC, 4'hF, 32'h1122_3344);
		io(1'b1, 16'h0CFC, 4'h3, 32'hAABB_CCDD);
		io(1'b0, 16'h0CFC, 4'hF, 32'h0);
		chk(r_data, 32'h1122_CCDD);
		chk({27'h0, int_dev}, 32'h10);
		chk({26'h0, int_reg}, 32'h5);
		chk({31'h0, saw_sl}, 32'h0);
		slow = 1'b0;
	endtask

	task automatic t_bus1();
		io(1'b1, 16'h0CF8, 4'hF, 32'h8001_0A04);
		io(1'b0, 16'h0CFC, 4'hF, 32'h0);
		chk(sl_addr, 32'h8001_0A05);
		chk(r_data, 32'h8001_0A05);
		chk({31'h0, saw_int}, 32'h0);
		io(1'b1, 16'h0CF8, 4'hF, 32'h8002_0000);
		io(1'b1, 16'h0CFC, 4'hF, 32'h55);
		chk({31'h0, r_abort}, 32'h1);
		chk({27'h0, sl_write, sl_be}, 32'h1F);
		chk(sl_wdata, 32'h0000_0055);
	endtask

	task automatic t_missing();
		io(1'b1, 16'h0CF8, 4'hF, 32'h8000_2800);
		io(1'b0, 16'h0CFC, 4'hF, 32'h0);
		chk({31'h0, saw_sl}, 32'h1);
		chk({30'h0, sl_addr[1:0]}, 32'h0);
		chk({31'h0, r_abort}, 32'h1);
		chk(r_data, 32'hFFFF_FFFF);
	endtask

	task automatic t_mapped();
		req(car_pkg::CAR_KIND_MEM_CFG, 1'b0, 32'h0008_0014, 4'hF, 32'h0);
		chk(r_data, 32'h1122_CCDD);
		req(car_pkg::CAR_KIND_FIXED, 1'b0, 32'h0000_1400, 4'h1, 32'h0);
		chk({28'h0, int_be}, 32'hF);
		chk({24'h0, int_dev, int_func}, 32'h80);
		chk(r_data, 32'h1122_CCDD);
		req(car_pkg::CAR_KIND_FIXED, 1'b0, 32'h0000_FC00, 4'hF, 32'h0);
		chk({31'h0, r_abort}, 32'h1);
		chk(r_data, 32'hFFFF_FFFF);
		chk({31'h0, saw_sl}, 32'h0);
		req(car_pkg::CAR_KIND_LINK_MEM_CFG, 1'b0, 32'h0008_0014, 4'hF,
			32'h0);
		chk({31'h0, r_abort}, 32'h1);
		chk(r_data, 32'hFFFF_FFFF);
		chk({31'h0, saw_int}, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		valid = 1'b0;
		wr = 1'b0;
		slow = 1'b0;
		kind = car_pkg::CAR_KIND_IO;
		addr = 32'h0;
		be = 4'h0;
		wdata = 32'h0;
		n_fail = 0;
		checks = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		t_select();
		t_reset();
		t_disabled();
		t_internal();
		t_bus1();
		t_missing();
		t_mapped();
		conclude();
	end
endmodule
